// file: usc_fifo.sv
// Small register-array FIFO with valid/ready on both sides
`timescale 1ns/1ps
module usc_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          flush,
  // Fill side
  input  wire logic          inValid,
  output logic               inReady,
  input  wire logic [W-1:0]  inData,
  // Drain side
  output logic               outValid,
  input  wire logic          outReady,
  output logic [W-1:0]       outData,
  output logic [CW-1:0]      count
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wrPtr_ff;
  logic [PW-1:0] rdPtr_ff;
  logic [CW-1:0] cnt_ff;
  wire           push = inValid & inReady;
  wire           pop  = outValid & outReady;

  assign inReady  = (cnt_ff != CW'(DEPTH));
  assign outValid = (cnt_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign count    = cnt_ff;

  function automatic logic [PW-1:0] incPtr(input logic [PW-1:0] p);
    incPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  // Flush drops everything at once; a push in that cycle is lost too
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff   <= '0;
    end else if (flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      cnt_ff   <= '0;
    end else begin
      if (push) wrPtr_ff <= incPtr(wrPtr_ff);
      if (pop) rdPtr_ff <= incPtr(rdPtr_ff);
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end
endmodule

// file: usc_pkg.sv
// Constants shared by the serial port status and control block
package usc_pkg;
  // Bus and register map
  localparam int unsigned ADDR_W   = 12;
  localparam logic [11:0] STA_OFS  = 12'h000;
  localparam logic [11:0] TXD_OFS  = 12'h004;
  localparam logic [11:0] RXD_OFS  = 12'h008;
  localparam logic [11:0] CFG_OFS  = 12'h00c;
  // Status and control field positions
  localparam int unsigned TXM1_B   = 15;
  localparam int unsigned TXINV_B  = 14;
  localparam int unsigned TXM0_B   = 13;
  localparam int unsigned BRK_B    = 11;
  localparam int unsigned TXEN_B   = 10;
  localparam int unsigned TXBF_B   = 9;
  localparam int unsigned TX_SHIFTER_EMPTY_B   = 8;
  localparam int unsigned RXM1_B   = 7;
  localparam int unsigned RXM0_B   = 6;
  localparam int unsigned ADET_B   = 5;
  localparam int unsigned RX_LINE_IDLE_B  = 4;
  localparam int unsigned PARITY_FAULT_B   = 3;
  localparam int unsigned FRAMING_FAULT_B   = 2;
  localparam int unsigned RX_OVERRUN_FLAG_B   = 1;
  localparam int unsigned RXDA_B   = 0;
  localparam int unsigned PAREN_B  = 0;
  localparam logic [15:0] STA_RST  = 16'h0110;
  // Interrupt mode codes
  localparam logic [1:0]  TXM_LOAD  = 2'h0;
  localparam logic [1:0]  TXM_DONE  = 2'h1;
  localparam logic [1:0]  TXM_EMPTY = 2'h2;
  localparam logic [1:0]  RXM_FULL  = 2'h3;
  localparam logic [1:0]  RXM_3Q    = 2'h2;
  // Character and buffer geometry
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned TX_DEPTH = 4;
  localparam int unsigned RX_DEPTH = 4;
  localparam int unsigned BAUD_DIV = 16;
  localparam int unsigned FRAME_W  = 14;
  localparam logic [3:0]  BRK_BITS = 4'he;
  localparam logic [3:0]  STD_BITS = 4'ha;
  localparam logic [3:0]  PAR_BITS = 4'hb;
endpackage

// file: usc_remote_xcvr.sv
// Remote serial transceiver model on the far side of the line
`timescale 1ns/1ps
module usc_remote_xcvr #(
  parameter int unsigned BAUD_DIV = 4
) (
  // Clock
  input  wire logic clk,
  // Line
  input  wire logic serialOutPin,
  input  wire logic watchEn,
  output logic      rxPin
);
  logic [8:0] heard[$];
  logic [8:0] shiftIn;

  // Line rests high between frames
  initial rxPin = 1'b1;

  // Start low, eight bits LSB first, then the given stop level
  task automatic sendChar(input logic [7:0] ch, input logic stopLvl);
    logic [9:0] frame;
    frame = {stopLvl, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxPin <= frame[i];
      repeat (BAUD_DIV) @(posedge clk);
    end
    rxPin <= 1'b1;
    repeat (BAUD_DIV) @(posedge clk);
  endtask

  // Mid-bit sampling; stop level kept so a bad frame shows up
  always begin
    @(posedge clk);
    if (watchEn === 1'b1 && serialOutPin === 1'b0) begin
      repeat (BAUD_DIV / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BAUD_DIV) @(posedge clk);
        shiftIn[i] = serialOutPin;
      end
      heard.push_back(shiftIn);
      while (serialOutPin !== 1'b1) @(posedge clk);
    end
  end
endmodule

// file: usc_uart_status_control.sv
// Serial port status/control register with transmit and receive engines
`timescale 1ns/1ps
module usc_uart_status_control #(
  parameter int unsigned BAUD_DIV = usc_pkg::BAUD_DIV
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [usc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Serial line and pin sharing
  input  wire logic                        rxPin,
  input  wire logic                        portLevel,
  input  wire logic                        infraredEncoderEnable,
  output logic                             serialOutPin,
  // Interrupt events
  output logic                             txIrq,
  output logic                             rxIrq
);
  import usc_pkg::*;

  localparam int unsigned BW  = $clog2(BAUD_DIV) + 1;
  localparam int unsigned TCW = $clog2(TX_DEPTH + 1);
  localparam int unsigned RCW = $clog2(RX_DEPTH + 1);

  typedef enum logic {TX_IDLE, TX_SHIFT} usc_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usc_rx_t;

  // Control and status flops
  logic [1:0]         txIrqMode_ff;
  logic               txIdleInvert_ff;
  logic               breakSendRequest_ff;
  logic               txEnableBit_ff;
  logic [1:0]         rxIrqMode_ff;
  logic               addressDetectEnable_ff;
  logic               parityEnable_ff;
  logic               rxOverrunFlag_ff;
  logic               parityFault_ff;
  logic               framingFault_ff;
  logic [31:0]        prdata_ff;
  // Transmit engine
  usc_tx_t            txState_ff;
  logic [FRAME_W-1:0] txShifter_ff;
  logic [3:0]         txBitsLeft_ff;
  logic [BW-1:0]      txBaud_ff;
  logic               txIsBreak_ff;
  logic               serialOut_ff;
  logic               txIrq_ff;
  // Receive engine
  usc_rx_t            rxState_ff;
  logic [DATA_W:0]    rxShifter_ff;
  logic [3:0]         rxBitIdx_ff;
  logic [BW-1:0]      rxBaud_ff;
  logic               rxIrq_ff;

  // Bus decode
  wire setupPh  = psel & ~penable;
  wire accessPh = psel & penable;
  wire hitSta   = (paddr == STA_OFS);
  wire hitTxd   = (paddr == TXD_OFS);
  wire hitRxd   = (paddr == RXD_OFS);
  wire hitCfg   = (paddr == CFG_OFS);
  wire hitAny   = hitSta | hitTxd | hitRxd | hitCfg;
  wire wrSta    = accessPh & pwrite & hitSta;
  wire wrTxd    = accessPh & pwrite & hitTxd;
  wire wrCfg    = accessPh & pwrite & hitCfg;
  wire rdRxd    = accessPh & ~pwrite & hitRxd;

  // Transmit buffer
  wire              txInReady;
  wire              txOutValid;
  wire [DATA_W-1:0] txHead;
  wire [TCW-1:0]    txCount;
  wire              txPush  = wrTxd & txEnableBit_ff & txInReady;
  wire              txIdle  = (txState_ff == TX_IDLE);
  wire              txTick  = ~txIdle & (txBaud_ff == '0);
  wire              txDone  = txTick & (txBitsLeft_ff == 4'h1);
  // A pending break goes ahead of any queued character
  wire              brkStart = txEnableBit_ff & txIdle & breakSendRequest_ff;
  wire              txLoad   = txEnableBit_ff & txIdle & txOutValid & ~breakSendRequest_ff;

  usc_fifo #(.W(DATA_W), .DEPTH(TX_DEPTH), .CW(TCW)) txBuf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .flush    (~txEnableBit_ff),
    .inValid  (wrTxd & txEnableBit_ff),
    .inReady  (txInReady),
    .inData   (pwdata[DATA_W-1:0]),
    .outValid (txOutValid),
    .outReady (txLoad),
    .outData  (txHead),
    .count    (txCount)
  );

  // Receive buffer; software reads drain it, so a stalled reader fills it
  wire              rxInReady;
  wire              rxOutValid;
  wire [DATA_W-1:0] rxHead;
  wire [RCW-1:0]    rxCount;
  wire              rxTick   = (rxState_ff != RX_IDLE) & (rxBaud_ff == '0);
  wire              rxFrame  = (rxState_ff == RX_STOP) & rxTick;
  wire              rxPush   = rxFrame & rxInReady;
  wire              ovrSet   = rxFrame & ~rxInReady;
  wire [DATA_W-1:0] rxData   = parityEnable_ff ? rxShifter_ff[DATA_W-1:0] : rxShifter_ff[DATA_W:1];
  wire              parBad   = parityEnable_ff & ((^rxShifter_ff[DATA_W-1:0]) ^ rxShifter_ff[DATA_W]);
  wire [3:0]        rxNeed   = parityEnable_ff ? 4'h8 : 4'h7;

  usc_fifo #(.W(DATA_W), .DEPTH(RX_DEPTH), .CW(RCW)) rxBuf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .flush    (1'b0),
    .inValid  (rxFrame),
    .inReady  (rxInReady),
    .inData   (rxData),
    .outValid (rxOutValid),
    .outReady (rdRxd),
    .outData  (rxHead),
    .count    (rxCount)
  );

  // Status word as software sees it
  wire txFull   = ~txInReady;
  wire shEmpty  = txIdle & ~txOutValid;
  wire rxIdleLn = (rxState_ff == RX_IDLE);
  wire [15:0] staVal = {txIrqMode_ff[1], txIdleInvert_ff, txIrqMode_ff[0], 1'b0,
                        breakSendRequest_ff, txEnableBit_ff, txFull, shEmpty,
                        rxIrqMode_ff, addressDetectEnable_ff, rxIdleLn,
                        parityFault_ff, framingFault_ff, rxOverrunFlag_ff, rxOutValid};
  wire [31:0] rdMux = hitSta ? {16'h0000, staVal} :
                      hitRxd ? {24'h000000, rxHead} :
                      hitCfg ? {31'h00000000, parityEnable_ff} : 32'h00000000;

  // Zero wait states; data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = accessPh & (~hitAny | (wrTxd & ~(txEnableBit_ff & txInReady)));
  assign prdata  = prdata_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) prdata_ff <= 32'h00000000;
    else if (setupPh) prdata_ff <= rdMux;
  end

  // Software-written control bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txIrqMode_ff           <= {STA_RST[TXM1_B], STA_RST[TXM0_B]};
      txIdleInvert_ff        <= STA_RST[TXINV_B];
      txEnableBit_ff         <= STA_RST[TXEN_B];
      rxIrqMode_ff           <= STA_RST[RXM1_B:RXM0_B];
      addressDetectEnable_ff <= STA_RST[ADET_B];
      parityEnable_ff        <= 1'b0;
    end else begin
      if (wrSta) begin
        txIrqMode_ff           <= {pwdata[TXM1_B], pwdata[TXM0_B]};
        txIdleInvert_ff        <= pwdata[TXINV_B];
        txEnableBit_ff         <= pwdata[TXEN_B];
        rxIrqMode_ff           <= pwdata[RXM1_B:RXM0_B];
        addressDetectEnable_ff <= pwdata[ADET_B];
      end
      if (wrCfg) parityEnable_ff <= pwdata[PAREN_B];
    end
  end

  // Hardware-maintained flags; a set beats a clear in the same cycle
  wire nxt_breakReq = wrSta ? pwdata[BRK_B] : (breakSendRequest_ff & ~(txDone & txIsBreak_ff));
  wire nxt_overrun  = ovrSet | (rxOverrunFlag_ff & ~(wrSta & ~pwdata[RX_OVERRUN_FLAG_B]));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      breakSendRequest_ff <= STA_RST[BRK_B];
      rxOverrunFlag_ff    <= STA_RST[RX_OVERRUN_FLAG_B];
      parityFault_ff      <= STA_RST[PARITY_FAULT_B];
      framingFault_ff     <= STA_RST[FRAMING_FAULT_B];
    end else begin
      breakSendRequest_ff <= nxt_breakReq;
      rxOverrunFlag_ff    <= nxt_overrun;
      if (rxPush) begin
        parityFault_ff  <= parBad;
        framingFault_ff <= ~rxPin;
      end
    end
  end

  // Transmit shifter; disabling aborts mid-frame
  wire [FRAME_W-1:0] frameStd = {4'hf, 1'b1, txHead, 1'b0};
  wire [FRAME_W-1:0] framePar = {3'h7, 1'b1, ^txHead, txHead, 1'b0};
  wire [FRAME_W-1:0] frameBrk = {1'b1, 13'h0000};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txState_ff    <= TX_IDLE;
      txShifter_ff  <= '1;
      txBitsLeft_ff <= 4'h0;
      txBaud_ff     <= '0;
      txIsBreak_ff  <= 1'b0;
    end else if (~txEnableBit_ff) begin
      txState_ff    <= TX_IDLE;
      txShifter_ff  <= '1;
      txIsBreak_ff  <= 1'b0;
    end else if (brkStart) begin
      txState_ff    <= TX_SHIFT;
      txShifter_ff  <= frameBrk;
      txBitsLeft_ff <= BRK_BITS;
      txBaud_ff     <= BW'(BAUD_DIV - 1);
      txIsBreak_ff  <= 1'b1;
    end else if (txLoad) begin
      txState_ff    <= TX_SHIFT;
      txShifter_ff  <= parityEnable_ff ? framePar : frameStd;
      txBitsLeft_ff <= parityEnable_ff ? PAR_BITS : STD_BITS;
      txBaud_ff     <= BW'(BAUD_DIV - 1);
      txIsBreak_ff  <= 1'b0;
    end else if (txTick) begin
      txShifter_ff  <= {1'b1, txShifter_ff[FRAME_W-1:1]};
      txBitsLeft_ff <= txBitsLeft_ff - 4'h1;
      txBaud_ff     <= BW'(BAUD_DIV - 1);
      if (txDone) txState_ff <= TX_IDLE;
    end else if (~txIdle) begin
      txBaud_ff     <= txBaud_ff - BW'(1);
    end
  end

  // Pin level; idle polarity flips with the encoder option
  wire txLine = txIdle ? 1'b1 : txShifter_ff[0];
  wire nxt_pin = txEnableBit_ff ? (txLine ^ (infraredEncoderEnable ^ txIdleInvert_ff)) : portLevel;

  // Transmit interrupt by mode; code 11 is reserved and stays silent
  wire txEvt = ((txIrqMode_ff == TXM_LOAD) & txLoad) |
               ((txIrqMode_ff == TXM_EMPTY) & txLoad & (txCount == TCW'(1)) & ~txPush) |
               ((txIrqMode_ff == TXM_DONE) & txDone & ~txOutValid);

  // Receive interrupt by mode, judged on the count before the push
  wire rxEvt = rxPush & (~rxIrqMode_ff[1] |
               ((rxIrqMode_ff == RXM_FULL) & (rxCount == RCW'(RX_DEPTH - 1))) |
               ((rxIrqMode_ff == RXM_3Q) & (rxCount == RCW'(RX_DEPTH - 2))));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      serialOut_ff <= 1'b1;
      txIrq_ff     <= 1'b0;
      rxIrq_ff     <= 1'b0;
    end else begin
      serialOut_ff <= nxt_pin;
      txIrq_ff     <= txEvt;
      rxIrq_ff     <= rxEvt;
    end
  end

  assign serialOutPin = serialOut_ff;
  assign txIrq        = txIrq_ff;
  assign rxIrq        = rxIrq_ff;

  // Receiver: mid-bit sampling; a short start pulse is treated as noise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxState_ff   <= RX_IDLE;
      rxShifter_ff <= '0;
      rxBitIdx_ff  <= 4'h0;
      rxBaud_ff    <= '0;
    end else begin
      unique case (rxState_ff)
        RX_IDLE: begin
          if (~rxPin) begin
            rxState_ff <= RX_START;
            rxBaud_ff  <= BW'(BAUD_DIV / 2 - 1);
          end
        end
        RX_START: begin
          if (rxTick) begin
            rxState_ff  <= rxPin ? RX_IDLE : RX_DATA;
            rxBitIdx_ff <= 4'h0;
            rxBaud_ff   <= BW'(BAUD_DIV - 1);
          end else rxBaud_ff <= rxBaud_ff - BW'(1);
        end
        RX_DATA: begin
          if (rxTick) begin
            rxShifter_ff <= {rxPin, rxShifter_ff[DATA_W:1]};
            rxBitIdx_ff  <= rxBitIdx_ff + 4'h1;
            rxBaud_ff    <= BW'(BAUD_DIV - 1);
            if (rxBitIdx_ff == rxNeed) rxState_ff <= RX_STOP;
          end else rxBaud_ff <= rxBaud_ff - BW'(1);
        end
        RX_STOP: begin
          if (rxTick) rxState_ff <= RX_IDLE;
          else rxBaud_ff <= rxBaud_ff - BW'(1);
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  fullFlag_a: assert property ((txCount == TCW'(TX_DEPTH)) |-> staVal[TXBF_B])
    else $error("full flag low with buffer full");
  shiftEmpty_a: assert property (txLoad |=> !staVal[TX_SHIFTER_EMPTY_B] ##1 !staVal[TX_SHIFTER_EMPTY_B])
    else $error("shifter empty while sending");
  txLoadIrq_a: assert property ((txIrqMode_ff == TXM_LOAD) && txLoad |=> txIrq)
    else $error("no irq on shifter load");
  txDoneIrq_a: assert property ((txIrqMode_ff == TXM_DONE) && txLoad |=> !txIrq)
    else $error("irq before transmission finished");
  breakClear_a: assert property ($fell(breakSendRequest_ff) && !$past(wrSta) |-> $past(txDone && txIsBreak_ff))
    else $error("break request cleared early");
  breakLow_a: assert property (brkStart |=> (txShifter_ff[0] == 1'b0) [*2])
    else $error("break not driving zeros");
  txAbort_a: assert property (!txEnableBit_ff |=> serialOutPin == $past(portLevel))
    else $error("pin not returned to port");
  idleLevel_a: assert property (txEnableBit_ff && txIdle && infraredEncoderEnable && !txIdleInvert_ff
                                |=> !serialOutPin)
    else $error("encoder idle level not low");
  rxThree_a: assert property ((rxIrqMode_ff == RXM_3Q) && rxPush && (rxCount == RCW'(2)) |=> rxIrq)
    else $error("no irq at three characters");
  rxAny_a: assert property (!rxIrqMode_ff[1] && rxPush |=> rxIrq && staVal[RXDA_B])
    else $error("no irq on received character");
  overrunSticky_a: assert property (ovrSet |=> rxOverrunFlag_ff ##1 (rxOverrunFlag_ff || $past(wrSta && !pwdata[RX_OVERRUN_FLAG_B])))
    else $error("overrun flag not held");
endmodule

// file: usc_uart_status_control_bench.sv
// Self-checking bench for the serial port status and control block
`timescale 1ns/1ps
`define USC_CHK(act, exp) begin checks++; if ((act) !== (exp)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, act, exp); end end
module usc_uart_status_control_bench;
  import usc_pkg::*;
  // Short bit time keeps the run brief
  localparam int unsigned BDIV = 4;
  // Clock, reset and bus
  logic        clk;
  logic        sysRst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Line and events
  logic        rxPin;
  logic        portLevel;
  logic        infrared_encoder_enable;
  logic        serialOutPin;
  logic        txIrq;
  logic        rxIrq;
  logic        watchEn;
  // Bench state
  int          fails = 0;
  int          checks = 0;
  int          txIrqCnt = 0;
  int          rxIrqCnt = 0;
  logic [31:0] rd;
  logic        err;

  usc_uart_status_control #(.BAUD_DIV(BDIV)) dut_u (
    .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPin(rxPin),
    .portLevel(portLevel), .infraredEncoderEnable(infrared_encoder_enable), .serialOutPin(serialOutPin),
    .txIrq(txIrq), .rxIrq(rxIrq)
  );

  usc_remote_xcvr #(.BAUD_DIV(BDIV)) farEnd (
    .clk(clk), .serialOutPin(serialOutPin), .watchEn(watchEn), .rxPin(rxPin)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pre-edge sampling counts a one-cycle pulse exactly once
  always @(posedge clk) begin
    if (txIrq === 1'b1) txIrqCnt++;
    if (rxIrq === 1'b1) rxIrqCnt++;
  end

  // Response taken at the committing edge, before its updates land
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int   n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdReg(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Overrun bit written as one so ordinary writes leave it alone
  function automatic logic [31:0] ctl(logic [1:0] txm, logic inv, logic brk, logic en, logic [1:0] rxm);
    return {16'h0, txm[1], inv, txm[0], 1'b0, brk, en, 2'b0, rxm, 6'h2};
  endfunction

  task automatic resetValues();
    rdReg(STA_OFS);
    `USC_CHK(rd[15:0], 16'h0110)
    rdReg(12'h010);
    `USC_CHK({err, rd}, 33'h1_0000_0000)
  endtask

  task automatic txModes();
    int         expIrq[4] = '{5, 1, 2, 0};
    logic [8:0] h;
    watchEn <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(STA_OFS, ctl(m[1:0], 1'b0, 1'b0, 1'b1, 2'h0));
      txIrqCnt = 0;
      for (int i = 0; i < 6; i++) wr(TXD_OFS, 32'h30 + i);
      `USC_CHK(err, 1'b1)
      rdReg(STA_OFS);
      `USC_CHK(rd[9:8], 2'b10)
      repeat (260) @(posedge clk);
      `USC_CHK(txIrqCnt, expIrq[m])
      rdReg(STA_OFS);
      `USC_CHK(rd[9:8], 2'b01)
      `USC_CHK(farEnd.heard.size(), 5)
      for (int i = 0; i < 5 && farEnd.heard.size() > 0; i++) begin
        h = farEnd.heard.pop_front();
        `USC_CHK(h, {1'b1, 8'h30 + 8'(i)})
      end
    end
    watchEn <= 1'b0;
  endtask

  task automatic idleLevels();
    for (int c = 0; c < 4; c++) begin
      infrared_encoder_enable <= c[1];
      wr(STA_OFS, ctl(2'h0, c[0], 1'b0, 1'b1, 2'h0));
      repeat (3) @(posedge clk);
      `USC_CHK(serialOutPin, ~(c[0] ^ c[1]))
    end
    infrared_encoder_enable <= 1'b0;
    wr(STA_OFS, ctl(2'h0, 1'b0, 1'b0, 1'b1, 2'h0));
  endtask

  // Disable lands in mid-frame with characters still queued
  task automatic disableAbort();
    for (int i = 0; i < 3; i++) wr(TXD_OFS, 32'h41 + i);
    repeat (10) @(posedge clk);
    wr(STA_OFS, ctl(2'h0, 1'b0, 1'b0, 1'b0, 2'h0));
    portLevel <= 1'b0;
    repeat (3) @(posedge clk);
    `USC_CHK(serialOutPin, 1'b0)
    rdReg(STA_OFS);
    `USC_CHK(rd[9:8], 2'b01)
    wr(TXD_OFS, 32'h5a);
    `USC_CHK(err, 1'b1)
    portLevel <= 1'b1;
    wr(STA_OFS, ctl(2'h0, 1'b0, 1'b0, 1'b1, 2'h0));
    repeat (60) @(posedge clk);
    rdReg(STA_OFS);
    `USC_CHK(rd[9:8], 2'b01)
  endtask

  task automatic breakFrame();
    int n;
    int low;
    n = 0;
    low = 0;
    wr(STA_OFS, ctl(2'h0, 1'b0, 1'b1, 1'b1, 2'h0));
    while (serialOutPin !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    while (serialOutPin === 1'b0 && low < 200) begin
      @(posedge clk);
      low++;
    end
    `USC_CHK(low, 13 * BDIV)
    repeat (2 * BDIV) @(posedge clk);
    rdReg(STA_OFS);
    `USC_CHK(rd[BRK_B], 1'b0)
  endtask

  task automatic rxModes();
    int expIrq[4] = '{4, 4, 1, 1};
    for (int m = 0; m < 4; m++) begin
      wr(STA_OFS, ctl(2'h0, 1'b0, 1'b0, 1'b1, m[1:0]));
      rxIrqCnt = 0;
      for (int i = 0; i < 4; i++) farEnd.sendChar(8'hc0 + 8'(i), 1'b1);
      repeat (4) @(posedge clk);
      `USC_CHK(rxIrqCnt, expIrq[m])
      rdReg(STA_OFS);
      `USC_CHK(rd[7:0], {m[1:0], 6'h11})
      for (int i = 0; i < 4; i++) begin
        rdReg(RXD_OFS);
        `USC_CHK(rd[7:0], 8'hc0 + 8'(i))
      end
    end
  endtask

  // Fifth character hits a full buffer; then a frame with its stop bit low
  task automatic rxFaults();
    wr(STA_OFS, ctl(2'h0, 1'b0, 1'b0, 1'b1, 2'h0) | 32'h20);
    for (int i = 0; i < 5; i++) farEnd.sendChar(8'h10 + 8'(i), 1'b1);
    rdReg(STA_OFS);
    `USC_CHK(rd[5:0], 6'h33)
    wr(STA_OFS, ctl(2'h0, 1'b0, 1'b0, 1'b1, 2'h0) & ~32'h2);
    rdReg(STA_OFS);
    `USC_CHK(rd[1:0], 2'b01)
    for (int i = 0; i < 4; i++) rdReg(RXD_OFS);
    farEnd.sendChar(8'h55, 1'b0);
    rdReg(STA_OFS);
    `USC_CHK(rd[2:0], 3'b101)
  endtask

  task automatic final_report();
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sysRst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    portLevel = 1'b1;
    infrared_encoder_enable = 1'b0;
    watchEn = 1'b0;
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    resetValues();
    txModes();
    idleLevels();
    disableAbort();
    breakFrame();
    rxModes();
    rxFaults();
    final_report();
  end

  // Whole run needs roughly two and a half thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule
